// ### dv/mcr_cfg_sva.sv
// assertion checker for the config register bank
`timescale 1ns/1ps
module mcr_cfg_sva
    import mcr_pkg::*;
#(
    parameter int     MON_W    = 12,
    parameter longint SLEEP_N3 = 50
) (
    input wire logic               i_clk_sys,
    input wire logic               i_rstn,
    input wire logic               i_ce,
    input wire logic [9:0]         i_avs_address,
    input wire logic               i_avs_write,
    input wire logic [3:0]         i_avs_byteenable,
    input wire logic [31:0]        i_avs_writedata,
    input wire logic               o_avs_waitrequest,
    input wire logic [MON_W-1:0]   i_conv2_data,
    input wire logic [MON_W-1:0]   i_phase_a_sense_out,
    input wire logic [MON_W-1:0]   i_phase_b_sense_out,
    input wire logic [MON_W-1:0]   i_phase_c_sense_out,
    input wire logic [MON_W-1:0]   i_conv1_data,
    input wire logic [MON_W-1:0]   o_monitor_out_one,
    input wire logic [MON_W-1:0]   o_monitor_out_two,
    input wire logic               o_monitor_on,
    input wire logic [1:0]         o_drive_code,
    input wire logic               o_pullup_on,
    input wire logic [1:0]         o_bus_voltage_range,
    input wire logic               o_bus_voltage_bad,
    input wire logic               i_speed_low,
    input wire logic               o_sleep,
    input wire logic               o_auto_current_gain_on,
    input wire logic               o_auto_voltage_gain_on,
    input wire mcr_pkg::mcr_clk_e  o_clk_src,
    input wire logic               o_outside_clock_on,
    input wire mcr_pkg::mcr_cfg_s  o_cfg
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    logic [31:0]      low_cnt_reg;
    longint           lim;
    logic [MON_W-1:0] route_src;
    logic [1:0]       sel;
    logic             wr_done;
    // consecutive cycles of low speed input
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            low_cnt_reg <= 32'h0;
        end else if (i_ce) begin
            low_cnt_reg <= i_speed_low ? low_cnt_reg + 32'h1 : 32'h0;
        end
    end
    assign sel = o_cfg.monitor_route_select;
    assign lim = (o_cfg.sleep_code == 2'h0) ? SLEEP_C0 : (o_cfg.sleep_code == 2'h1) ? SLEEP_C1
               : (o_cfg.sleep_code == 2'h2) ? SLEEP_C2 : SLEEP_N3;
    assign route_src = sel[1] ? (sel[0] ? i_phase_c_sense_out : i_phase_b_sense_out)
                              : (sel[0] ? i_phase_a_sense_out : i_conv2_data);
    assign wr_done = i_avs_write && !o_avs_waitrequest && i_avs_byteenable == 4'hf;
    chk_reset_zero: assert property ($rose(i_rstn) |-> o_cfg == '0 && !o_sleep)
        else $error("config not zero after reset");
    chk_write_pin: assert property (wr_done && i_avs_address == PIN_MON_ADDR
        |=> o_drive_code == $past(i_avs_writedata[4:3]) && o_pullup_on == $past(i_avs_writedata[2])
        && o_bus_voltage_range == $past(i_avs_writedata[1:0]))
        else $error("pin setup fields do not follow write");
    chk_write_clk: assert property (wr_done && i_avs_address == CLK_SLP_ADDR
        |=> o_cfg.full_freq == $past(i_avs_writedata[30:16])
        && o_auto_current_gain_on == $past(i_avs_writedata[13])
        && o_auto_voltage_gain_on == $past(i_avs_writedata[12]))
        else $error("clock setup fields do not follow write");
    chk_mon_off: assert property (!o_monitor_on && !$past(o_monitor_on)
        |-> o_monitor_out_one == '0 && o_monitor_out_two == '0)
        else $error("monitor outputs active while disabled");
    chk_route_sel: assert property ($past(o_monitor_on) |->
        o_monitor_out_two == $past(route_src) && o_monitor_out_one == $past(i_conv1_data))
        else $error("monitor output source wrong");
    chk_busv_bad: assert property ($stable(o_bus_voltage_range)
        |-> o_bus_voltage_bad == (o_bus_voltage_range == 2'h3))
        else $error("undefined bus voltage flag wrong");
    chk_clk_ext: assert property (o_clk_src == CLK_EXT |-> o_outside_clock_on)
        else $error("external clock without enable");
    chk_clk_na: assert property (o_cfg.clk_src == 2'h2 |-> o_clk_src == CLK_INT)
        else $error("clock source code 2 used");
    chk_sleep_time: assert property ($rose(o_sleep) && lim > 0
        |-> low_cnt_reg + 2 >= lim && low_cnt_reg <= lim + 1)
        else $error("sleep entered at wrong time");
endmodule : mcr_cfg_sva

// ### dv/mcr_config_regs_tb.sv
// self-checking bench for the config register bank
`timescale 1ns/1ps
module mcr_config_regs_tb;
    import mcr_pkg::*;
    logic        i_clk_sys = 1'b0;
    logic        i_rstn = 1'b0;
    logic        i_ce = 1'b1;
    logic [9:0]  i_avs_address = 10'h0;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [3:0]  i_avs_byteenable = 4'hf;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [31:0] o_avs_readdata;
    logic        o_avs_waitrequest;
    logic [11:0] i_conv2_data = 12'h111;
    logic [11:0] i_phase_a_sense_out = 12'h222;
    logic [11:0] i_phase_b_sense_out = 12'h333;
    logic [11:0] i_phase_c_sense_out = 12'h444;
    logic [11:0] i_conv1_data = 12'h555;
    logic [11:0] o_monitor_out_one, o_monitor_out_two;
    logic        o_monitor_on, o_pullup_on, o_bus_voltage_bad, o_duty_valid, o_sleep;
    logic        o_auto_current_gain_on, o_auto_voltage_gain_on, o_outside_clock_on;
    logic [1:0]  o_drive_code, o_bus_voltage_range;
    logic        i_freq_valid = 1'b0;
    logic [14:0] i_freq_meas = 15'h0;
    logic [15:0] o_duty;
    logic        i_speed_low = 1'b0;
    mcr_clk_e    o_clk_src;
    mcr_cfg_s    o_cfg;
    int          errors = 0;
    int          checks_done = 0;
    logic [31:0] rd;

    always #2.5 i_clk_sys = ~i_clk_sys;

    mcr_config_regs #(.SLEEP_N3(50)) i_mcr_config_regs (.*);

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : cyc

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        i_avs_address   <= a;
        i_avs_writedata <= d;
        i_avs_write     <= wr;
        i_avs_read      <= !wr;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_avs_waitrequest !== 1'b0);
        rd = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read  <= 1'b0;
        check("bus wait", n, 32'h2);
    endtask : bus

    task automatic t_reset();
        bus(1'b0, PIN_MON_ADDR, 32'h0);
        check("pin_monitor_setup", rd, PIN_MON_RST);
        bus(1'b0, CLK_SLP_ADDR, 32'h0);
        check("clock_sleep_setup", rd, CLK_SLP_RST);
        check("cfg", {2'b00, o_cfg}, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_pin();
        bus(1'b1, PIN_MON_ADDR, 32'hffff_ffff);
        bus(1'b0, PIN_MON_ADDR, 32'h0);
        check("pin readback", rd, PIN_MON_MASK);
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, PIN_MON_ADDR, {2'b00, k[1:0], 1'b1, 22'h0, k[1:0], k[0], k[1:0]});
            cyc(2);
            check("out two", o_monitor_out_two, 12'(12'h111 * (k + 1)));
            check("out one", o_monitor_out_one, 12'h555);
            check("mon on", o_monitor_on, 1'b1);
            check("drive", o_drive_code, k[1:0]);
            check("pullup", o_pullup_on, k[0]);
            check("busv", o_bus_voltage_range, k[1:0]);
            check("busv bad", o_bus_voltage_bad, k == 3);
        end
        bus(1'b1, PIN_MON_ADDR, 32'h3000_0000);
        cyc(2);
        check("off one", o_monitor_out_one, 32'h0);
        check("off two", o_monitor_out_two, 32'h0);
        bus(1'b1, 10'h004, 32'hffff_ffff);
        bus(1'b0, 10'h004, 32'h0);
        check("unmapped", rd, UNMAPPED_RDATA);
        i_avs_byteenable <= 4'h1;
        bus(1'b1, PIN_MON_ADDR, 32'hffff_ffff);
        i_avs_byteenable <= 4'hf;
        bus(1'b0, PIN_MON_ADDR, 32'h0);
        check("pin kept", rd, 32'h3000_001f);
        $display("test pin setup done");
    endtask : t_pin

    task automatic t_clk();
        bus(1'b1, CLK_SLP_ADDR, 32'hffff_ffff);
        bus(1'b0, CLK_SLP_ADDR, 32'h0);
        check("clk readback", rd, CLK_SLP_MASK);
        for (int k = 0; k < 8; k++) begin
            bus(1'b1, CLK_SLP_ADDR, {18'h0, k[0], !k[0], 1'b0, k[1:0], k[2], 8'h0});
            cyc(1);
            check("clk src", o_clk_src, (k % 4 == 1) ? CLK_CRUDE : (k == 7) ? CLK_EXT : CLK_INT);
            check("ext on", o_outside_clock_on, k[2]);
            check("cur gain", o_auto_current_gain_on, k[0]);
            check("volt gain", o_auto_voltage_gain_on, !k[0]);
        end
        $display("test clock setup done");
    endtask : t_clk

    task automatic t_sleep(input logic [1:0] code, input int n);
        bus(1'b1, CLK_SLP_ADDR, {16'h0, code, 14'h0});
        @(posedge i_clk_sys);
        i_speed_low <= 1'b1;
        cyc(n - 4);
        check("early sleep", o_sleep, 1'b0);
        cyc(8);
        check("sleep", o_sleep, 1'b1);
        i_speed_low <= 1'b0;
        cyc(4);
        $display("test sleep done");
    endtask : t_sleep

    // clock enable low freezes the sleep timer
    task automatic t_hold();
        @(posedge i_clk_sys);
        i_ce        <= 1'b0;
        i_speed_low <= 1'b1;
        cyc(80);
        check("frozen sleep", o_sleep, 1'b0);
        i_ce <= 1'b1;
        cyc(60);
        check("sleep after hold", o_sleep, 1'b1);
        i_speed_low <= 1'b0;
        cyc(4);
        $display("test hold done");
    endtask : t_hold

    task automatic t_duty(input logic [14:0] full, input logic [14:0] meas, input logic [15:0] exp);
        int n;
        n = 0;
        bus(1'b1, CLK_SLP_ADDR, {1'b0, full, 16'h0});
        @(posedge i_clk_sys);
        i_freq_meas  <= meas;
        i_freq_valid <= 1'b1;
        @(posedge i_clk_sys);
        i_freq_valid <= 1'b0;
        while (o_duty_valid !== 1'b1 && n < 200) begin
            @(posedge i_clk_sys);
            n++;
        end
        check("duty valid", o_duty_valid, 1'b1);
        check("duty", o_duty, exp);
        $display("test duty done");
    endtask : t_duty

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        cyc(16);
        i_rstn <= 1'b1;
        t_reset();
        t_pin();
        t_clk();
        t_sleep(2'h3, 50);
        t_hold();
        t_sleep(2'h0, int'(SLEEP_C0));
        t_sleep(2'h1, int'(SLEEP_C1));
        t_duty(15'h64, 15'h64, 16'h8000);
        t_duty(15'h64, 15'h32, 16'h4000);
        t_duty(15'h0, 15'h7, 16'h8000);
        t_duty(15'h3, 15'h1, 16'h2aaa);
        report_and_stop();
    end

    initial begin
        cyc(80000);
        errors++;
        report_and_stop();
    end
endmodule : mcr_config_regs_tb

bind mcr_config_regs mcr_cfg_sva #(.MON_W(MON_W), .SLEEP_N3(SLEEP_N3)) i_mcr_cfg_sva (.*);

// ### pkg/mcr_pkg.sv
// package for the motor config register bank
package mcr_pkg;
    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 32;
    // printed offsets are not multiples of four: index kept, byte address = 4 * index
    localparam logic [7:0]  PIN_MON_IDX      = 8'ha6;
    localparam logic [7:0]  CLK_SLP_IDX      = 8'ha8;
    localparam logic [9:0]  PIN_MON_ADDR     = {PIN_MON_IDX, 2'b00};
    localparam logic [9:0]  CLK_SLP_ADDR     = {CLK_SLP_IDX, 2'b00};
    localparam logic [31:0] PIN_MON_RST      = 32'h0000_0000;
    localparam logic [31:0] CLK_SLP_RST      = 32'h0000_0000;
    // writable masks: fields outside the implemented ones read zero
    localparam logic [31:0] PIN_MON_MASK     = 32'h3800_001f;
    localparam logic [31:0] CLK_SLP_MASK     = 32'h7fff_f700;
    localparam int          MON_SEL_LSB      = 28;
    localparam int          MON_EN_BIT       = 27;
    localparam int          DRIVE_LSB        = 3;
    localparam int          PULLUP_BIT       = 2;
    localparam int          BUSV_LSB         = 0;
    localparam int          FULL_FREQ_LSB    = 16;
    localparam int          SLEEP_LSB        = 14;
    localparam int          AUTO_CUR_BIT     = 13;
    localparam int          AUTO_VOLT_BIT    = 12;
    localparam int          CLK_SRC_LSB      = 9;
    localparam int          OUT_CLK_BIT      = 8;
    localparam logic [31:0] UNMAPPED_RDATA   = 32'h0000_0000;
    // sleep entry times in microseconds and clock rate
    localparam longint      CLK_HZ           = 200_000_000;
    localparam longint      SLEEP_T0_US      = 50;
    localparam longint      SLEEP_T1_US      = 200;
    localparam longint      SLEEP_T2_US      = 20_000;
    localparam longint      SLEEP_T3_US      = 200_000;
    localparam longint      SLEEP_C0         = (SLEEP_T0_US * CLK_HZ + 999_999) / 1_000_000;
    localparam longint      SLEEP_C1         = (SLEEP_T1_US * CLK_HZ + 999_999) / 1_000_000;
    localparam longint      SLEEP_C2         = (SLEEP_T2_US * CLK_HZ + 999_999) / 1_000_000;
    localparam longint      SLEEP_C3         = (SLEEP_T3_US * CLK_HZ + 999_999) / 1_000_000;

    typedef enum logic [1:0] {MON_CONV2, MON_PH_A, MON_PH_B, MON_PH_C} mcr_mon_e;
    typedef enum logic [1:0] {CLK_INT, CLK_CRUDE, CLK_NA, CLK_EXT} mcr_clk_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [9:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } mcr_bus_s;

    typedef struct packed {
        logic [1:0]  monitor_route_select;
        logic        monitor_on;
        logic [1:0]  drive_code;
        logic        pullup_on;
        logic [1:0]  bus_voltage_range;
        logic [14:0] full_freq;
        logic [1:0]  sleep_code;
        logic        auto_current_gain_on;
        logic        auto_voltage_gain_on;
        logic [1:0]  clk_src;
        logic        outside_clock_on;
    } mcr_cfg_s;
endpackage : mcr_pkg

// ### rtl/mcr_config_regs.sv
// configuration register bank with monitor routing, sleep timer and speed scaling
// Functional notes
// [R1] both registers reset to all zero
// [R2] bits 29-28 route second monitor output
// [R3] bit 27 enables both monitor outputs
// [R4] bits 4-3 set serial pin drive
// [R5] bit 2 enables fault/feedback pull-ups
// [R6] bits 1-0 select maximum bus voltage
// [R7] bits 30-16 full-scale input frequency
// [R8] bits 15-14 select sleep entry delay
// [R9] bit 13 enables automatic current gain
// [R10] bit 12 enables automatic voltage gain
// [R11] bits 10-9 select clock source
// [R12] bit 8 enables external clock mode
`timescale 1ns/1ps
module mcr_config_regs #(
    parameter int     MON_W    = 12,
    parameter int     FREQ_W   = 15,
    parameter longint SLEEP_N3 = mcr_pkg::SLEEP_C3
) (
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_rstn,
    input  wire logic                    i_ce,
    input  wire logic [9:0]              i_avs_address,
    input  wire logic                    i_avs_read,
    input  wire logic                    i_avs_write,
    input  wire logic [3:0]              i_avs_byteenable,
    input  wire logic [31:0]             i_avs_writedata,
    output logic [31:0]                  o_avs_readdata,
    output logic                         o_avs_waitrequest,
    input  wire logic [MON_W-1:0]        i_conv2_data,
    input  wire logic [MON_W-1:0]        i_phase_a_sense_out,
    input  wire logic [MON_W-1:0]        i_phase_b_sense_out,
    input  wire logic [MON_W-1:0]        i_phase_c_sense_out,
    input  wire logic [MON_W-1:0]        i_conv1_data,
    output logic [MON_W-1:0]             o_monitor_out_one,
    output logic [MON_W-1:0]             o_monitor_out_two,
    output logic                         o_monitor_on,
    output logic [1:0]                   o_drive_code,
    output logic                         o_pullup_on,
    output logic [1:0]                   o_bus_voltage_range,
    output logic                         o_bus_voltage_bad,
    input  wire logic                    i_freq_valid,
    input  wire logic [FREQ_W-1:0]       i_freq_meas,
    output logic                         o_duty_valid,
    output logic [15:0]                  o_duty,
    input  wire logic                    i_speed_low,
    output logic                         o_sleep,
    output logic                         o_auto_current_gain_on,
    output logic                         o_auto_voltage_gain_on,
    output mcr_pkg::mcr_clk_e            o_clk_src,
    output logic                         o_outside_clock_on,
    output mcr_pkg::mcr_cfg_s            o_cfg
);
    import mcr_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_ACK} mcr_bus_st_e;
    localparam int CNT_W = 26;

    logic [31:0]      pin_mon_reg;
    logic [31:0]      clk_slp_reg;
    logic [31:0]      wmask;
    mcr_bus_s         bus;
    mcr_bus_st_e      st_reg;
    logic [CNT_W-1:0] sleep_limit;
    logic [FREQ_W:0]  div_rem_reg;
    logic [15:0]      div_q_reg;
    logic [4:0]       div_cnt_reg;
    logic             div_busy_reg;
    logic [FREQ_W-1:0]  div_full_reg;
    logic [FREQ_W:0]    rem_shift;
    logic               rem_fits;
    logic               div_start;
    logic               div_sat;
    logic               div_last;

    localparam logic [4:0]  DIV_STEPS = 5'h0f;
    localparam logic [15:0] DUTY_FULL = 16'h8000;

    assign bus = '{wr: i_avs_write, rd: i_avs_read, addr: i_avs_address,
                   be: i_avs_byteenable, wdata: i_avs_writedata};

    always_comb begin
        wmask = {{8{bus.be[3]}}, {8{bus.be[2]}}, {8{bus.be[1]}}, {8{bus.be[0]}}};
    end

    // one wait cycle per access, answered in ST_ACK
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= ST_IDLE;
        end else if (i_ce) begin
            case (st_reg)
                ST_IDLE: begin
                    if (bus.rd || bus.wr) begin
                        st_reg <= ST_ACK;
                    end
                end
                default: begin
                    st_reg <= ST_IDLE;
                end
            endcase
        end
    end

    assign o_avs_waitrequest = (bus.rd || bus.wr) && !(st_reg == ST_ACK && i_ce);

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_mon_reg <= PIN_MON_RST; // [R1]
            clk_slp_reg <= CLK_SLP_RST; // [R1]
        end else if (i_ce && st_reg == ST_ACK && bus.wr) begin
            if (bus.addr == PIN_MON_ADDR) begin
                pin_mon_reg <= (pin_mon_reg & ~wmask)
                             | (bus.wdata & wmask & PIN_MON_MASK);
            end else if (bus.addr == CLK_SLP_ADDR) begin
                clk_slp_reg <= (clk_slp_reg & ~wmask)
                             | (bus.wdata & wmask & CLK_SLP_MASK);
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_ce && st_reg == ST_IDLE && bus.rd) begin
            if (bus.addr == PIN_MON_ADDR) begin
                o_avs_readdata <= pin_mon_reg;
            end else if (bus.addr == CLK_SLP_ADDR) begin
                o_avs_readdata <= clk_slp_reg;
            end else begin
                o_avs_readdata <= UNMAPPED_RDATA;
            end
        end
    end

    // decoded configuration
    always_comb begin
        o_cfg.monitor_route_select = pin_mon_reg[MON_SEL_LSB +: 2];
        o_cfg.monitor_on           = pin_mon_reg[MON_EN_BIT];
        o_cfg.drive_code           = pin_mon_reg[DRIVE_LSB +: 2];
        o_cfg.pullup_on            = pin_mon_reg[PULLUP_BIT];
        o_cfg.bus_voltage_range    = pin_mon_reg[BUSV_LSB +: 2];
        o_cfg.full_freq            = clk_slp_reg[FULL_FREQ_LSB +: 15];
        o_cfg.sleep_code           = clk_slp_reg[SLEEP_LSB +: 2];
        o_cfg.auto_current_gain_on = clk_slp_reg[AUTO_CUR_BIT];
        o_cfg.auto_voltage_gain_on = clk_slp_reg[AUTO_VOLT_BIT];
        o_cfg.clk_src              = clk_slp_reg[CLK_SRC_LSB +: 2];
        o_cfg.outside_clock_on     = clk_slp_reg[OUT_CLK_BIT];
    end

    assign o_monitor_on           = o_cfg.monitor_on;
    assign o_drive_code           = o_cfg.drive_code;           // [R4]
    assign o_pullup_on            = o_cfg.pullup_on;            // [R5]
    assign o_bus_voltage_range    = o_cfg.bus_voltage_range;    // [R6]
    assign o_bus_voltage_bad      = (o_cfg.bus_voltage_range == 2'h3); // [R6]
    assign o_auto_current_gain_on = o_cfg.auto_current_gain_on; // [R9]
    assign o_auto_voltage_gain_on = o_cfg.auto_voltage_gain_on; // [R10]
    assign o_outside_clock_on     = o_cfg.outside_clock_on;     // [R12]

    // external source only counts while external clock mode is on
    always_comb begin
        case (o_cfg.clk_src)
            2'h1:    o_clk_src = CLK_CRUDE;   // [R11]
            2'h3:    o_clk_src = o_cfg.outside_clock_on ? CLK_EXT : CLK_INT; // [R11] [R12]
            default: o_clk_src = CLK_INT;     // [R11]
        endcase
    end

    // monitor outputs, registered, zero while disabled
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_monitor_out_one <= '0;
            o_monitor_out_two <= '0;
        end else if (i_ce) begin
            if (!o_cfg.monitor_on) begin // [R3]
                o_monitor_out_one <= '0;
                o_monitor_out_two <= '0;
            end else begin
                o_monitor_out_one <= i_conv1_data;
                case (mcr_mon_e'(o_cfg.monitor_route_select)) // [R2]
                    MON_CONV2: o_monitor_out_two <= i_conv2_data;
                    MON_PH_A:  o_monitor_out_two <= i_phase_a_sense_out;
                    MON_PH_B:  o_monitor_out_two <= i_phase_b_sense_out;
                    default:   o_monitor_out_two <= i_phase_c_sense_out;
                endcase
            end
        end
    end

    // sleep entry delay selection
    always_comb begin
        case (o_cfg.sleep_code) // [R8]
            2'h0:    sleep_limit = CNT_W'(SLEEP_C0);
            2'h1:    sleep_limit = CNT_W'(SLEEP_C1);
            2'h2:    sleep_limit = CNT_W'(SLEEP_C2);
            default: sleep_limit = CNT_W'(SLEEP_N3);
        endcase
    end

    mcr_sleep_timer #(
        .CNT_W       (CNT_W)
    ) u_sleep (
        .i_clk_sys   (i_clk_sys),
        .i_rstn      (i_rstn),
        .i_ce        (i_ce),
        .i_speed_low (i_speed_low),
        .i_limit     (sleep_limit),
        .o_sleep     (o_sleep)
    );

    // duty = measured / full scale, q1.15 with 16'h8000 = full, saturated
    // restoring division: remainder doubled, full scale taken off when it fits
    assign rem_shift = {div_rem_reg[FREQ_W-1:0], 1'b0};
    assign rem_fits  = (rem_shift >= {1'b0, div_full_reg});
    assign div_start = !div_busy_reg && i_freq_valid;
    assign div_sat   = (o_cfg.full_freq == 15'h0) || (i_freq_meas >= o_cfg.full_freq); // [R7]
    assign div_last  = div_busy_reg && (div_cnt_reg == 5'h01);

    // divider sequencing: fifteen steps give the fifteen fraction bits
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            div_busy_reg <= 1'b0;
            div_cnt_reg  <= 5'h00;
        end else if (i_ce) begin
            if (div_start && !div_sat) begin
                div_busy_reg <= 1'b1;
                div_cnt_reg  <= DIV_STEPS;
            end else if (div_busy_reg) begin
                div_cnt_reg <= div_cnt_reg - 5'h01;
                if (div_last) begin
                    div_busy_reg <= 1'b0;
                end
            end
        end
    end

    // full scale latched at start so a register write cannot upset a running division
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            div_full_reg <= '0;
        end else if (i_ce) begin
            if (div_start && !div_sat) begin
                div_full_reg <= o_cfg.full_freq;
            end
        end
    end

    // remainder and quotient shift registers
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            div_rem_reg <= '0;
            div_q_reg   <= 16'h0000;
        end else if (i_ce) begin
            if (div_start && !div_sat) begin
                div_rem_reg <= {1'b0, i_freq_meas};
                div_q_reg   <= 16'h0000;
            end else if (div_busy_reg) begin
                if (rem_fits) begin
                    div_rem_reg <= rem_shift - {1'b0, div_full_reg}; // [R7]
                end else begin
                    div_rem_reg <= rem_shift;
                end
                div_q_reg <= {div_q_reg[14:0], rem_fits};
            end
        end
    end

    // result register: saturated at once, quotient after the last step
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_duty_valid <= 1'b0;
            o_duty       <= 16'h0000;
        end else if (i_ce) begin
            o_duty_valid <= (div_start && div_sat) || div_last; // [R7]
            if (div_start && div_sat) begin
                o_duty <= DUTY_FULL; // [R7]
            end else if (div_last) begin
                o_duty <= {div_q_reg[14:0], rem_fits}; // [R7]
            end
        end
    end
endmodule : mcr_config_regs

// ### rtl/mcr_sleep_timer.sv
// sleep entry timer: counts cycles of low speed input
`timescale 1ns/1ps
module mcr_sleep_timer #(
    parameter int CNT_W = 26
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rstn,
    input  wire logic             i_ce,
    input  wire logic             i_speed_low,
    input  wire logic [CNT_W-1:0] i_limit,
    output logic                  o_sleep
);
    logic [CNT_W-1:0] cnt_reg;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_reg <= '0;
        end else if (i_ce) begin
            if (!i_speed_low) begin
                cnt_reg <= '0;
            end else if (cnt_reg < i_limit) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sleep <= 1'b0;
        end else if (i_ce) begin
            o_sleep <= i_speed_low && (cnt_reg >= i_limit - 1'b1);
        end
    end
endmodule : mcr_sleep_timer
